// File: core/chp_pkg.sv
// Constants for the stored-program channel processor
`default_nettype none
package chp_pkg;
    localparam int          CLK_MHZ    = 200;
    localparam int          FIFO_DEPTH = 8;
    localparam int          DW         = 18;
    localparam int          AW         = 15;
    // Command word fields
    localparam int          CMD_Q      = 17;
    localparam int          CMD_H      = 16;
    localparam int          CMD_N_LO   = 9;
    localparam int          CMD_A_LO   = 5;
    localparam logic [17:0] EXIT_CODE  = 18'h3FFFF;
    localparam logic [4:0]  N_CTRL     = 5'h17;
    // Function codes
    localparam logic [4:0]  F_READ     = 5'h01;
    localparam logic [4:0]  F_INC_A    = 5'h04;
    localparam logic [4:0]  F_INC_B    = 5'h06;
    localparam logic [4:0]  F_RD_LAST  = 5'h07;
    localparam logic [4:0]  F_CLR      = 5'h0A;
    localparam logic [4:0]  F_CLR_EN   = 5'h0B;
    localparam logic [4:0]  F_JUMP     = 5'h0C;
    localparam logic [4:0]  F_WR_FIRST = 5'h10;
    localparam logic [4:0]  F_WR_LAST  = 5'h13;
    localparam logic [4:0]  F_LOAD     = 5'h11;
    localparam logic [4:0]  F_STOP     = 5'h19;
    // Control module subaddresses
    localparam logic [3:0]  A_CA0      = 4'h0;
    localparam logic [3:0]  A_WC0      = 4'h2;
    localparam logic [3:0]  A_STAT     = 4'h4;
    // Word-count/enable layout, vector index = 17 - printed bit
    localparam int          WCE_R18    = 16;
    localparam int          WCE_EN0    = 15;
    localparam int          WC_OVF     = 11;
    localparam logic [5:0]  EN_CLEARED = 6'h00;
    // Status word layout
    localparam int          ST_TAG     = 17;
    localparam int          ST_SKIP    = 2;
    // Event table base (octal 24)
    localparam logic [14:0] EVT_BASE   = 15'h0014;
endpackage : chp_pkg
`default_nettype wire

// File: core/chp_channel_processor.sv
// Channel processor: event monitor, program sequencer, subchannels, write FIFO
`default_nettype none

module chp_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             resetn,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW:0]      wp_r;
    logic [PW:0]      rp_r;
    wire              push = in_valid & in_ready;
    wire              pop  = out_valid & out_ready;

    assign in_ready  = (wp_r - rp_r) != (PW+1)'(DEPTH);
    assign out_valid = wp_r != rp_r;
    assign out_data  = mem_r[rp_r[PW-1:0]];

    always_ff @(posedge core_clk)
    begin
        if (push)
        begin
            mem_r[wp_r[PW-1:0]] <= in_data;
        end
        if (!resetn)
        begin
            wp_r <= '0;
            rp_r <= '0;
        end
        else
        begin
            wp_r <= wp_r + (PW+1)'(push);
            rp_r <= rp_r + (PW+1)'(pop);
        end
    end
endmodule // chp_fifo

// Summary of operation
// R01: Four event inputs start channel programs
// R02: Run commands in order, stop on exit
// R03: Q mismatch skips the following command
// R04: Skip sets status bit until next event
// R05: Plain read stores 17 bits, 18 optional
// R06: High read stores seven high, then low
// R07: Write sends 18 bits, or six plus 18
// R08: F4/F6 increment memory at module data
// R09: F12 jumps within current page
// R10: Two subchannels, each event owned by one
// R11: Current address holds next buffer cell
// R12: Enable bits 2-5 enable events 0-3
// R13: Each transfer bumps count and address
// R14: Count overflow ends record after event
// R15: Software loads negated buffer size
// R16: Stop commands act like count overflow
// R17: Subchannel runs until end of record
// R18: Status read stores tagged event descriptor
// R19: Event start loads pointer into counter
// R20: Table word with top bit is command
// R21: Disabled event still latches, runs later
// R22: Software loads address before enabling
// R23: Event 0 highest priority, one at a time
// R24: Event table at octal 24 to 27
// R25: Increment is uninterrupted read-modify-write
module chp_channel_processor (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // Event inputs from the crate
    input  wire logic [3:0]  event_pin,
    output logic [3:0]       event_active,
    output logic             busy,
    output logic [1:0]       end_of_record,
    // Host memory data channel
    output logic             mem_req,
    output logic             mem_we,
    output logic [14:0]      mem_addr,
    output logic [17:0]      mem_wdata,
    input  wire logic        mem_ack,
    input  wire logic [17:0] mem_rdata,
    // Dataway
    output logic             dw_req,
    output logic [17:0]      dw_cmd,
    output logic [23:0]      dw_wdata,
    input  wire logic        dw_done,
    input  wire logic [23:0] dw_rdata,
    input  wire logic        dw_q,
    // Control module access from the CPU side
    input  wire logic        ctl_req,
    input  wire logic [4:0]  ctl_func,
    input  wire logic [3:0]  ctl_sub,
    input  wire logic [17:0] ctl_wdata,
    output logic             ctl_ack,
    output logic [17:0]      ctl_rdata
);
    typedef enum logic [3:0] {
        ST_IDLE, ST_TABLE, ST_FETCH, ST_EXEC, ST_MRD_HI, ST_MRD_LO, ST_DWAY,
        ST_PUSH_HI, ST_PUSH_LO, ST_INC_RD, ST_INC_WR, ST_CTRL, ST_END
    } chp_state_t;

    chp_state_t   state_r;
    logic [14:0]  pc_r;
    logic [17:0]  cmd_r;
    logic         direct_r;
    logic         skip_r;
    logic [1:0]   ev_num_r;
    logic         act_sub_r;
    logic [23:0]  data_r;
    logic         keep_msb_r;
    logic [17:0]  incval_r;
    logic [14:0]  ca_r  [2];
    logic [17:0]  wce_r [2];
    logic [1:0]   eor_pend_r;
    logic [3:0]   latch_r;
    logic [3:0]   sync1_r;
    logic [3:0]   sync2_r;
    logic [3:0]   sync3_r;
    logic         own_fsm_r;

    // Event monitor
    wire  [3:0]  ev_rise = sync2_r & ~sync3_r;
    // Event e enable sits at index WCE_EN0 - e, so the field is read bit-reversed
    wire  [3:0]  ev_en0;
    wire  [3:0]  ev_en1;
    wire  [3:0]  ev_gate = (state_r == ST_IDLE) ? latch_r & (ev_en0 | ev_en1) : 4'h0;
    wire         ev_any  = |ev_gate;
    wire  [1:0]  ev_pick = ev_gate[0] ? 2'd0 : ev_gate[1] ? 2'd1 :
                           ev_gate[2] ? 2'd2 : 2'd3; // [R23]
    wire         ev_sub  = ~ev_en0[ev_pick]; // [R10]

    // Command decode
    wire  [4:0]  c_f     = cmd_r[4:0];
    wire  [3:0]  c_a     = cmd_r[chp_pkg::CMD_A_LO +: 4];
    wire         c_ctrl  = cmd_r[chp_pkg::CMD_N_LO +: 5] == chp_pkg::N_CTRL;
    wire         c_write = (c_f >= chp_pkg::F_WR_FIRST) && (c_f <= chp_pkg::F_WR_LAST);
    wire         c_read  = c_f <= chp_pkg::F_RD_LAST;
    wire         c_inc   = (c_f == chp_pkg::F_INC_A) || (c_f == chp_pkg::F_INC_B);
    wire         c_exit  = cmd_r == chp_pkg::EXIT_CODE;
    wire         q_miss  = dw_done && (dw_q != cmd_r[chp_pkg::CMD_Q]);
    wire  [14:0] pc_inc  = {pc_r[14:12], pc_r[11:0] + 12'h001};
    // PC already points past this command, so one more step drops the next one
    wire  [14:0] pc_skip = {pc_r[14:12], pc_r[11:0] + 12'h001};
    chp_state_t  st_next;
    assign st_next = direct_r ? ST_END : ST_FETCH;

    // Memory port: FSM reads wait for an empty FIFO so buffer order holds
    wire         fifo_in_ready;
    wire         fifo_out_valid;
    wire  [32:0] fifo_out_data;
    wire  [32:0] fifo_in_data;
    wire         fsm_rd  = (state_r == ST_TABLE) || (state_r == ST_FETCH) ||
                           (state_r == ST_MRD_HI) || (state_r == ST_MRD_LO) ||
                           (state_r == ST_INC_RD);
    wire         fsm_wr  = state_r == ST_INC_WR;
    wire         fifo_empty = ~fifo_out_valid;
    wire         load_fsm = ~mem_req && (fsm_rd || fsm_wr) && fifo_empty;
    // Buffer writes drain even while the FSM waits to read, else both would stall
    wire         load_fifo = ~mem_req && ~load_fsm && fifo_out_valid;
    wire         fsm_ack = mem_ack && own_fsm_r;
    wire  [14:0] fsm_addr = (state_r == ST_TABLE) ? chp_pkg::EVT_BASE + 15'(ev_num_r) : // [R24]
                            (state_r == ST_FETCH) ? pc_r :
                            (state_r == ST_INC_RD || state_r == ST_INC_WR) ?
                            data_r[14:0] : ca_r[act_sub_r];

    // Buffer transfers
    wire         push_go = ((state_r == ST_PUSH_HI) || (state_r == ST_PUSH_LO)) &&
                           fifo_in_ready;
    wire         xfer    = push_go || (fsm_ack &&
                           ((state_r == ST_MRD_HI) || (state_r == ST_MRD_LO)));
    wire  [17:0] lo_word = keep_msb_r ? data_r[17:0] : {1'b0, data_r[16:0]};
    wire  [17:0] push_wd = (state_r == ST_PUSH_HI) ? {11'h000, data_r[23:17]} :
                           lo_word; // [R05] [R06]
    assign fifo_in_data = {ca_r[act_sub_r], push_wd};

    // Control module access, program side has precedence
    wire         fsm_ctl = state_r == ST_CTRL;
    wire         host_go = ctl_req && !fsm_ctl;
    wire         ctl_go  = fsm_ctl || host_go;
    wire  [4:0]  k_f     = fsm_ctl ? c_f : ctl_func;
    wire  [3:0]  k_a     = fsm_ctl ? c_a : ctl_sub;
    wire  [17:0] k_wd    = fsm_ctl ? 18'h00000 : ctl_wdata;
    wire  [17:0] stat_w  = {1'b1, 14'h0000, skip_r, ev_num_r}; // [R18]
    wire  [17:0] k_rd    = (k_a == chp_pkg::A_STAT) ? stat_w :
                           (k_a == chp_pkg::A_WC0 || k_a == chp_pkg::A_WC0 + 4'h1) ?
                           {6'h00, wce_r[k_a[0]][11:0]} : 18'h00000;
    wire         clr_latch = ctl_go && k_f == chp_pkg::F_CLR && k_a == chp_pkg::A_CA0;
    wire         end_now = state_r == ST_END;

    // Per-subchannel registers
    for (genvar s = 0; s < 2; s++)
    begin : g_sub
        wire        sel_ca  = ctl_go && k_f == chp_pkg::F_LOAD && k_a == chp_pkg::A_CA0 + 4'(s);
        wire        sel_wc  = ctl_go && k_f == chp_pkg::F_LOAD && k_a == chp_pkg::A_WC0 + 4'(s);
        wire        clr_en  = ctl_go && k_f == chp_pkg::F_CLR_EN && k_a == chp_pkg::A_WC0 + 4'(s);
        wire        stop    = ctl_go && k_f == chp_pkg::F_STOP && k_a == chp_pkg::A_CA0 + 4'(s);
        wire        clr_eor = ctl_go && k_f == chp_pkg::F_CLR && k_a == chp_pkg::A_WC0 + 4'(s);
        wire        mine    = xfer && act_sub_r == 1'(s);
        wire [11:0] wc_inc  = wce_r[s][11:0] + 12'h001;
        wire        ovf     = mine && !wce_r[s][chp_pkg::WC_OVF] && wc_inc[chp_pkg::WC_OVF];
        wire        finish  = end_now && eor_pend_r[s];
        always_ff @(posedge core_clk)
        begin
            if (!resetn)
            begin
                ca_r[s]          <= 15'h0000;
                wce_r[s]         <= 18'h00000;
                eor_pend_r[s]    <= 1'b0;
                end_of_record[s] <= 1'b0;
            end
            else
            begin
                if (sel_ca)
                    ca_r[s] <= k_wd[14:0];
                else if (mine)
                    ca_r[s] <= {ca_r[s][14:12], ca_r[s][11:0] + 12'h001}; // [R11] [R13]
                if (sel_wc)
                    wce_r[s] <= {1'b0, k_wd[16:0]}; // [R12]
                else
                begin
                    if (mine)
                        wce_r[s][11:0] <= wc_inc; // [R13]
                    if (clr_en || stop || finish)
                        wce_r[s][17:12] <= chp_pkg::EN_CLEARED; // [R14] [R16] [R17]
                end
                if (finish)
                    eor_pend_r[s] <= 1'b0;
                else if (ovf)
                    eor_pend_r[s] <= 1'b1; // [R14]
                if (stop || finish)
                    end_of_record[s] <= 1'b1; // [R16]
                else if (clr_eor)
                    end_of_record[s] <= 1'b0;
            end
        end
    end

    // Event latches, a new request wins over any clear
    for (genvar e = 0; e < 4; e++)
    begin : g_evt
        wire start_e = ev_any && ev_pick == 2'(e);
        assign ev_en0[e] = wce_r[0][chp_pkg::WCE_EN0 - e]; // [R12]
        assign ev_en1[e] = wce_r[1][chp_pkg::WCE_EN0 - e]; // [R12]
        always_ff @(posedge core_clk)
        begin
            if (!resetn)
                latch_r[e] <= 1'b0;
            else if (ev_rise[e])
                latch_r[e] <= 1'b1; // [R01] [R21]
            else if (start_e || clr_latch)
                latch_r[e] <= 1'b0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            sync1_r <= 4'h0;
            sync2_r <= 4'h0;
            sync3_r <= 4'h0;
        end
        else
        begin
            sync1_r <= event_pin;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // Memory port registers
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            mem_req   <= 1'b0;
            mem_we    <= 1'b0;
            mem_addr  <= 15'h0000;
            mem_wdata <= 18'h00000;
            own_fsm_r <= 1'b0;
        end
        else if (mem_req)
        begin
            mem_req <= !mem_ack;
        end
        else if (load_fsm)
        begin
            mem_req   <= 1'b1;
            mem_we    <= fsm_wr;
            mem_addr  <= fsm_addr;
            mem_wdata <= incval_r + 18'h00001; // [R08]
            own_fsm_r <= 1'b1;
        end
        else if (load_fifo)
        begin
            mem_req   <= 1'b1;
            mem_we    <= 1'b1;
            mem_addr  <= fifo_out_data[32:18];
            mem_wdata <= fifo_out_data[17:0];
            own_fsm_r <= 1'b0;
        end
    end

    chp_fifo #(
        .WIDTH (33),
        .DEPTH (chp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .resetn    (resetn),
        .in_valid  (push_go),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (fifo_out_valid),
        .out_ready (load_fifo),
        .out_data  (fifo_out_data)
    );

    // Sequencer
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            state_r    <= ST_IDLE;
            pc_r       <= 15'h0000;
            cmd_r      <= 18'h00000;
            direct_r   <= 1'b0;
            skip_r     <= 1'b0;
            ev_num_r   <= 2'd0;
            act_sub_r  <= 1'b0;
            data_r     <= 24'h000000;
            keep_msb_r <= 1'b0;
            incval_r   <= 18'h00000;
            dw_req     <= 1'b0;
            dw_cmd     <= 18'h00000;
            dw_wdata   <= 24'h000000;
            ctl_ack    <= 1'b0;
            ctl_rdata  <= 18'h00000;
        end
        else
        begin
            ctl_ack <= host_go;
            if (host_go)
                ctl_rdata <= k_rd;
            case (state_r)
                ST_IDLE:
                    if (ev_any)
                    begin
                        ev_num_r  <= ev_pick;
                        act_sub_r <= ev_sub;
                        skip_r    <= 1'b0; // [R04]
                        state_r   <= ST_TABLE;
                    end
                ST_TABLE:
                    if (fsm_ack)
                    begin
                        cmd_r    <= mem_rdata;
                        pc_r     <= mem_rdata[14:0]; // [R19]
                        direct_r <= mem_rdata[17];
                        state_r  <= mem_rdata[17] ? ST_EXEC : ST_FETCH; // [R20]
                    end
                ST_FETCH:
                    if (fsm_ack)
                    begin
                        cmd_r   <= mem_rdata;
                        pc_r    <= pc_inc;
                        state_r <= ST_EXEC;
                    end
                ST_EXEC:
                begin
                    keep_msb_r <= wce_r[act_sub_r][chp_pkg::WCE_R18];
                    if (c_exit)
                        state_r <= ST_END; // [R02]
                    else if (c_f == chp_pkg::F_JUMP)
                    begin
                        pc_r[11:0] <= cmd_r[11:0]; // [R09]
                        state_r    <= st_next;
                    end
                    else if (c_ctrl)
                        state_r <= ST_CTRL;
                    else if (c_write)
                        state_r <= cmd_r[chp_pkg::CMD_H] ? ST_MRD_HI : ST_MRD_LO; // [R07]
                    else
                    begin
                        dw_cmd  <= cmd_r;
                        dw_req  <= 1'b1;
                        state_r <= ST_DWAY;
                    end
                end
                ST_MRD_HI:
                    if (fsm_ack)
                    begin
                        dw_wdata[23:18] <= mem_rdata[5:0]; // [R07]
                        state_r         <= ST_MRD_LO;
                    end
                ST_MRD_LO:
                    if (fsm_ack)
                    begin
                        if (!cmd_r[chp_pkg::CMD_H])
                            dw_wdata[23:18] <= 6'h00;
                        dw_wdata[17:0] <= mem_rdata;
                        dw_cmd         <= cmd_r;
                        dw_req         <= 1'b1;
                        state_r        <= ST_DWAY;
                    end
                ST_DWAY:
                    if (dw_done)
                    begin
                        dw_req <= 1'b0;
                        data_r <= dw_rdata;
                        if (q_miss)
                        begin
                            skip_r <= 1'b1; // [R04]
                            pc_r   <= pc_skip; // [R03]
                        end
                        if (c_inc)
                            state_r <= ST_INC_RD;
                        else if (c_read)
                            state_r <= cmd_r[chp_pkg::CMD_H] ? ST_PUSH_HI : ST_PUSH_LO;
                        else
                            state_r <= st_next;
                    end
                ST_PUSH_HI:
                    if (fifo_in_ready)
                        state_r <= ST_PUSH_LO; // [R06]
                ST_PUSH_LO:
                    if (fifo_in_ready)
                        state_r <= st_next;
                ST_INC_RD:
                    if (fsm_ack)
                    begin
                        incval_r <= mem_rdata;
                        state_r  <= ST_INC_WR; // [R25]
                    end
                ST_INC_WR:
                    if (fsm_ack)
                        state_r <= st_next;
                ST_CTRL:
                begin
                    data_r     <= {6'h00, k_rd};
                    keep_msb_r <= 1'b1;
                    state_r    <= (c_f == chp_pkg::F_READ) ? ST_PUSH_LO : st_next; // [R18]
                end
                ST_END:
                    state_r <= ST_IDLE;
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    assign busy = state_r != ST_IDLE;
    for (genvar e = 0; e < 4; e++)
    begin : g_light
        assign event_active[e] = busy && ev_num_r == 2'(e);
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence s_exit_seen;
        state_r == ST_EXEC && c_exit;
    endsequence
    sequence s_wind_down;
        state_r == ST_END ##1 state_r == ST_IDLE;
    endsequence

    prio_start_a: assert property (ev_gate[0] |=> state_r == ST_TABLE && ev_num_r == 2'd0) // [R23]
        else $error("event 0 not served first");
    table_addr_a: assert property (state_r == ST_TABLE && mem_req && own_fsm_r
        |-> mem_addr == chp_pkg::EVT_BASE + 15'(ev_num_r)) // [R24]
        else $error("wrong event table address");
    exit_stop_a: assert property (s_exit_seen |=> s_wind_down) // [R02]
        else $error("exit did not stop program");
    skip_flag_a: assert property (state_r == ST_DWAY && q_miss
        |=> skip_r && pc_r == {$past(pc_r[14:12]), $past(pc_r[11:0]) + 12'h001}) // [R03]
        else $error("Q mismatch did not skip");
    jump_page_a: assert property (state_r == ST_EXEC && !c_exit && c_f == chp_pkg::F_JUMP
        |=> pc_r == {$past(pc_r[14:12]), $past(cmd_r[11:0])}) // [R09]
        else $error("jump left page or wrong target");
    stop_eor_a: assert property (ctl_go && k_f == chp_pkg::F_STOP && k_a == chp_pkg::A_CA0
        |=> end_of_record[0] && wce_r[0][17:12] == chp_pkg::EN_CLEARED) // [R16]
        else $error("stop did not end record");
    xfer_count_a: assert property (xfer && !act_sub_r && !g_sub[0].sel_ca
        |=> ca_r[0][11:0] == $past(ca_r[0][11:0]) + 12'h001) // [R13]
        else $error("address not bumped on transfer");
    latch_hold_a: assert property (ev_rise[1] |=> latch_r[1]) // [R21]
        else $error("event request lost");
    inc_rmw_a: assert property (state_r == ST_INC_WR && mem_req && own_fsm_r
        |-> mem_we && mem_wdata == incval_r + 18'h00001) // [R08]
        else $error("increment write wrong");
endmodule // chp_channel_processor
`default_nettype wire

// File: testbench/chp_host_model.sv
// Host memory and crate module model facing the channel processor
`default_nettype none
module chp_host_model (
    // Clock
    input  wire logic        core_clk,
    // Memory channel
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [14:0] mem_addr,
    input  wire logic [17:0] mem_wdata,
    output logic             mem_ack,
    output logic [17:0]      mem_rdata,
    // Dataway module
    input  wire logic        dw_req,
    output logic             dw_done,
    output logic [23:0]      dw_rdata,
    output logic             dw_q,
    // Module response chosen by the bench
    input  wire logic [23:0] dw_value,
    input  wire logic        dw_qval
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [17:0] mem [0:511];
    initial
    begin
        for (int i = 0; i < 512; i++) mem[i] = 18'h3FFFF;
        {mem_ack, dw_done, dw_q} = 3'h0;
        mem_rdata = 18'h00000;
        dw_rdata = 24'h000000;
    end
    // Outside an answer the buses toggle so stale data is never mistaken for valid
    always @(posedge core_clk)
    begin
        mem_ack <= mem_req && !mem_ack;
        mem_rdata <= (mem_req && !mem_ack) ? mem[mem_addr[8:0]] : ~mem_rdata;
        if (mem_req && mem_ack && mem_we)
            mem[mem_addr[8:0]] <= mem_wdata;
        dw_done <= dw_req && !dw_done;
        dw_rdata <= (dw_req && !dw_done) ? dw_value : ~dw_rdata;
        dw_q <= (dw_req && !dw_done) ? dw_qval : ~dw_q;
    end
endmodule // chp_host_model
`default_nettype wire

// File: testbench/stored_program_channel_processor_tb_top.sv
// Bench for the channel processor: control access, one event program, memory checks
`default_nettype none
module stored_program_channel_processor_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk, resetn, ctl_req, ctl_ack, mem_req, mem_we, mem_ack;
    logic dw_req, dw_done, dw_q, busy;
    logic [3:0] event_pin, event_active;
    logic [1:0] end_of_record;
    logic [4:0] ctl_func;
    logic [3:0] ctl_sub;
    logic [17:0] ctl_wdata, ctl_rdata, mem_wdata, mem_rdata, dw_cmd, rd;
    logic [14:0] mem_addr;
    logic [23:0] dw_wdata, dw_rdata;
    int bad_count, checks;
    chp_channel_processor chp_channel_processor_i (.core_clk(core_clk), .resetn(resetn),
        .event_pin(event_pin), .event_active(event_active), .busy(busy),
        .end_of_record(end_of_record), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .dw_req(dw_req), .dw_cmd(dw_cmd), .dw_wdata(dw_wdata),
        .dw_done(dw_done), .dw_rdata(dw_rdata), .dw_q(dw_q), .ctl_req(ctl_req),
        .ctl_func(ctl_func), .ctl_sub(ctl_sub), .ctl_wdata(ctl_wdata),
        .ctl_ack(ctl_ack), .ctl_rdata(ctl_rdata));
    chp_host_model chp_host_model_i (.core_clk(core_clk), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .dw_req(dw_req), .dw_done(dw_done), .dw_rdata(dw_rdata),
        .dw_q(dw_q), .dw_value(24'h000080), .dw_qval(1'b0));
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic final_report();
        if (bad_count == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic compare(input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask
    // Request held from a falling edge until the acknowledge is seen
    task automatic ctl_access(input logic [4:0] f, input logic [3:0] a,
                              input logic [17:0] d);
        int n;
        n = 0;
        ctl_func = f;
        ctl_sub = a;
        ctl_wdata = d;
        ctl_req = 1'b1;
        do
        begin
            @(negedge core_clk);
            n++;
        end
        while (ctl_ack !== 1'b1 && n < 20);
        rd = ctl_rdata;
        ctl_req = 1'b0;
        if (ctl_ack !== 1'b1)
        begin
            bad_count++;
            final_report();
        end
        // One idle edge so a following call never re-raises the request at once
        @(negedge core_clk);
    endtask
    task automatic wait_busy(input logic lvl, input int lim);
        int n;
        n = 0;
        while (busy !== lvl && n < lim)
        begin
            @(negedge core_clk);
            n++;
        end
        if (busy !== lvl)
        begin
            bad_count++;
            final_report();
        end
    endtask
    initial
    begin
        {resetn, ctl_req, event_pin, ctl_func, ctl_sub, ctl_wdata} = '0;
        bad_count = 0;
        checks = 0;
        repeat (3) @(negedge core_clk);
        resetn = 1'b1;
        compare({end_of_record, busy, mem_req, dw_req}, 24'h0);
        // Table entry and a program with skip, increment, jump and descriptor
        chp_host_model_i.mem[9'h014] = 18'h00040;
        chp_host_model_i.mem[9'h040] = 18'h20A01;
        chp_host_model_i.mem[9'h041] = 18'h00A10;
        chp_host_model_i.mem[9'h042] = 18'h00A04;
        chp_host_model_i.mem[9'h043] = 18'h0004C;
        chp_host_model_i.mem[9'h044] = 18'h00A01;
        chp_host_model_i.mem[9'h04C] = 18'h02E81;
        // Buffer address before enable, count of minus two, event 0 enabled
        ctl_access(chp_pkg::F_LOAD, chp_pkg::A_CA0, 18'h00100);
        ctl_access(chp_pkg::F_LOAD, chp_pkg::A_WC0, 18'h087FE);
        ctl_access(chp_pkg::F_READ, chp_pkg::A_WC0, 18'h00000);
        compare(rd, 18'h007FE);
        repeat (4) @(negedge core_clk);
        // Event 1 rises too but stays latched while no subchannel enables it
        event_pin = 4'h3;
        wait_busy(1'b1, 20);
        compare(event_active, 4'h1);
        repeat (4) @(negedge core_clk);
        event_pin = 4'h0;
        wait_busy(1'b0, 400);
        compare(chp_host_model_i.mem[9'h100], 18'h00080);
        compare(chp_host_model_i.mem[9'h101], 18'h20004);
        compare(chp_host_model_i.mem[9'h080], 18'h00000);
        compare(chp_host_model_i.mem[9'h102], 18'h3FFFF);
        compare(end_of_record, 2'h1);
        compare(dw_cmd, 18'h00A04);
        compare(dw_wdata, 24'h000000);
        compare({mem_we, mem_addr}, 16'h004D);
        ctl_access(chp_pkg::F_CLR, chp_pkg::A_WC0, 18'h00000);
        compare(end_of_record, 2'h0);
        ctl_access(chp_pkg::F_STOP, chp_pkg::A_CA0, 18'h00000);
        compare(end_of_record, 2'h1);
        // Enabling event 1 runs its latched request; its table word is a direct exit
        ctl_access(chp_pkg::F_LOAD, chp_pkg::A_WC0 + 4'h1, 18'h04000);
        wait_busy(1'b1, 20);
        compare(event_active, 4'h2);
        wait_busy(1'b0, 40);
        final_report();
    end
endmodule // stored_program_channel_processor_tb_top
`default_nettype wire
